// ---- rtl/rfsh_pkg.sv ----
// Shared constants and types for the refresh-scheduling command link
package rfsh_pkg;

  // ==========================================================
  // Geometry and widths
  localparam int NB     = 8;
  localparam int BAW    = 3;
  localparam int CAW    = 5;
  localparam int TW     = 4;
  localparam int WIN_W  = 20;
  localparam int OWED_W = 14;
  localparam int BEAT_W = 32;
  localparam int GRP_W  = 64;

  // ==========================================================
  // Command encodings, CA2..CA0 in ca[2:0]
  localparam logic [2:0] CA_REF = 3'h4;
  localparam logic [2:0] CA_WR  = 3'h1;
  localparam logic [2:0] CA_PRE = 3'h3;
  localparam logic [2:0] CA_NOP = 3'h7;
  localparam logic [1:0] CA_ACT = 2'h2;
  localparam int         CA_SEL = 3;
  localparam int         CA_ALL = 4;

  // ==========================================================
  // Timing, times in ns, counts in sys_clk cycles
  localparam int T_CK_NS    = 100;
  localparam int T_RFCAB_NS = 130;
  localparam int T_RFCPB_NS = 60;
  localparam int T_RRD_NS   = 10;
  localparam int T_RP_NS    = 18;
  localparam int T_WR_NS    = 15;
  localparam int T_REFI_NS  = 3906;
  localparam int T_REFW_NS  = 32000000;
  localparam int T_REFBW_NS = 4 * 8 * T_RFCAB_NS;
  localparam int REF_COUNT  = 8192;
  localparam int AB_PER_BW  = 8;
  localparam int WL         = 1;
  localparam int BL         = 4;

  // Least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + T_CK_NS - 1) / T_CK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  // Longest times round down, never below one cycle
  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / T_CK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_dn

  localparam int RFCAB_CYC  = cyc_up(T_RFCAB_NS);
  localparam int RFCPB_CYC  = cyc_up(T_RFCPB_NS);
  localparam int RRD_CYC    = cyc_up(T_RRD_NS);
  localparam int RP_CYC     = cyc_up(T_RP_NS);
  localparam int WR_CYC     = cyc_up(T_WR_NS);
  localparam int REFI_CYC   = cyc_dn(T_REFI_NS);
  localparam int REFW_CYC   = cyc_dn(T_REFW_NS);
  localparam int AB_GAP_CYC = cyc_up(T_REFBW_NS / AB_PER_BW);
  localparam int WR_REC_CYC = WL + BL / 2 + 1 + WR_CYC;
  localparam int BEATS      = BL / 2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {OP_ACT = 2'h0, OP_WR = 2'h1, OP_PRE = 2'h2} rfsh_op_e;
  typedef enum logic [1:0] {PH_RUN = 2'h0, PH_DRAIN = 2'h1, PH_REF = 2'h3} rfsh_ph_e;

endpackage : rfsh_pkg

// ---- rtl/rfsh_if.sv ----
// Command and write-data link between memory controller and device
`timescale 1ns/1ps
interface rfsh_if import rfsh_pkg::*;
  ;
  logic              cs_n;
  logic [CAW-1:0]    ca;
  logic [BAW-1:0]    ba;
  logic              wd_valid;
  logic [BEAT_W-1:0] wd;

  modport ctl (output cs_n, output ca, output ba, output wd_valid, output wd);
  modport dev (input cs_n, input ca, input ba, input wd_valid, input wd);
endinterface : rfsh_if

// ---- rtl/rfsh_tmr.sv ----
// Load-and-count-down interval timer, busy for val-1 cycles after load
`timescale 1ns/1ps
module rfsh_tmr import rfsh_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          load,
  input  wire logic [TW-1:0] val,
  output logic               busy
);

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          busy;
  } rfsh_tmr_s;

  rfsh_tmr_s t_reg;
  rfsh_tmr_s t_next;

  // A command at cycle c frees the next one at c+val
  always_comb
  begin
    t_next = t_reg;
    if (load)
      t_next.cnt = (val == '0) ? '0 : val - TW'(1);
    else if (t_reg.cnt != '0)
      t_next.cnt = t_reg.cnt - TW'(1);
    t_next.busy = (t_next.cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign busy = t_reg.busy;

endmodule : rfsh_tmr

// ---- rtl/rfsh_dev.sv ----
// Device end: refresh decode, per-bank counter, bank state, write prefetch
`timescale 1ns/1ps
module rfsh_dev import rfsh_pkg::*;
#(
  parameter bit EIGHT_BANKS = 1'b1
)
(
  input  wire logic      sys_clk,
  input  wire logic      rstn,
  rfsh_if.dev            link,
  input  wire logic      reset_cmd,
  input  wire logic      sr_exit,
  output logic [NB-1:0]  bank_open,
  output logic [NB-1:0]  bank_rfsh,
  output logic [BAW-1:0] ref_ptr,
  output logic           arr_we,
  output logic [BAW-1:0] arr_bank,
  output logic [GRP_W-1:0] arr_data,
  output logic           cmd_err
);

  typedef struct packed {
    logic [NB-1:0]     open;
    logic [BAW-1:0]    ptr;
    logic [BAW-1:0]    wr_bank;
    logic              half;
    logic [BEAT_W-1:0] low;
    logic              we;
    logic [BAW-1:0]    abank;
    logic [GRP_W-1:0]  adata;
    logic              err;
  } rfsh_dev_s;

  rfsh_dev_s d_reg;
  rfsh_dev_s d_next;
  logic [NB-1:0] rb;
  logic [NB-1:0] ld;
  logic is_ref, is_act, is_wr, is_pre, ab_ok, pb_req, pb_ok;

  // ==========================================================
  // Command decode at the rising edge
  assign is_ref = !link.cs_n && (link.ca[2:0] == CA_REF);
  assign is_act = !link.cs_n && (link.ca[1:0] == CA_ACT);
  assign is_wr  = !link.cs_n && (link.ca[2:0] == CA_WR);
  assign is_pre = !link.cs_n && (link.ca[2:0] == CA_PRE);
  assign pb_req = is_ref && !link.ca[CA_SEL];
  // Per-bank form only on eight-bank parts
  assign pb_ok  = pb_req && EIGHT_BANKS && !d_reg.open[d_reg.ptr] && !rb[d_reg.ptr];
  assign ab_ok  = is_ref && link.ca[CA_SEL] && (d_reg.open == '0) && (rb == '0);

  // ==========================================================
  // Per-bank refresh busy timers; bank idles when they expire
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_bank
      assign ld[gi] = ab_ok || (pb_ok && (d_reg.ptr == BAW'(gi)));
      rfsh_tmr u_rf (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (ld[gi]),
        .val     (ab_ok ? TW'(RFCAB_CYC) : TW'(RFCPB_CYC)),
        .busy    (rb[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Bank state, counter and prefetch capture
  always_comb
  begin
    d_next     = d_reg;
    d_next.we  = 1'b0;
    d_next.err = 1'b0;
    if (reset_cmd || sr_exit || ab_ok)
      d_next.ptr = '0;
    else if (pb_ok)
      d_next.ptr = d_reg.ptr + BAW'(1);
    // Refused refreshes leave bank state and counter untouched
    if (is_ref && !ab_ok && !pb_ok)
      d_next.err = 1'b1;
    if (is_act)
    begin
      // Only a refreshing or already open bank refuses; others stay usable
      if (rb[link.ba] || d_reg.open[link.ba])
        d_next.err = 1'b1;
      else
        d_next.open[link.ba] = 1'b1;
    end
    if (is_pre)
    begin
      if (link.ca[CA_ALL])
        d_next.open = '0;
      else
        d_next.open[link.ba] = 1'b0;
    end
    if (is_wr)
    begin
      if (!d_reg.open[link.ba])
        d_next.err = 1'b1;
      d_next.wr_bank = link.ba;
      d_next.half    = 1'b0;
    end
    // Array write starts only once four words are latched
    if (link.wd_valid)
    begin
      if (!d_reg.half)
      begin
        d_next.low  = link.wd;
        d_next.half = 1'b1;
      end
      else
      begin
        d_next.half  = 1'b0;
        d_next.we    = 1'b1;
        d_next.abank = d_reg.wr_bank;
        d_next.adata = {link.wd, d_reg.low};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      d_reg <= '0;
    else
      d_reg <= d_next;
  end

  assign bank_open = d_reg.open;
  assign bank_rfsh = rb;
  assign ref_ptr   = d_reg.ptr;
  assign arr_we    = d_reg.we;
  assign arr_bank  = d_reg.abank;
  assign arr_data  = d_reg.adata;
  assign cmd_err   = d_reg.err;

endmodule : rfsh_dev

// ---- rtl/rfsh_ctl.sv ----
// Controller end: command timing, refresh scheduling and write data issue
//
// Notes on behaviour
// - write to precharge waits WL+BL/2+1+RU(write_recovery_time)
// - array write after four prefetched words
// - write recovery counted from last data
// - refresh is CS low, CA 0-0-1, CA3 selects
// - per-bank refresh only on eight-bank devices
// - per-bank refresh walks banks zero to seven
// - counter clears on reset, self-refresh exit, all-bank
// - controller mirrors counter, targets only idle bank; its copy clears only on all-bank refresh, not on reset or self-refresh exit
// - per-bank refresh waits ab, pb, precharge, activate gaps
// - refreshing bank unavailable, others stay usable
// - per-bank refresh leaves that bank idle
// - after per-bank refresh wait cycle, activate gap
// - all banks idle before all-bank refresh
// - all-bank refresh waits ab, pb, precharge gaps
// - all-bank refresh leaves every bank idle
// - after all-bank refresh wait full cycle
// - distributed schedule, one refresh per interval
// - burst then pause bounded by window
// - every rolling window gets required refreshes
// - burst to distributed only right after burst
// - self refresh counts as distributed refresh
// - at most eight all-bank refreshes per burst window
// - eight per-bank refreshes count as one
`timescale 1ns/1ps
module rfsh_ctl import rfsh_pkg::*;
#(
  parameter int REFW_CYCLES = REFW_CYC
)
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  rfsh_if.ctl              link,
  input  wire logic        u_valid,
  input  wire rfsh_op_e    u_op,
  input  wire logic [BAW-1:0] u_bank,
  input  wire logic        u_all,
  input  wire logic [GRP_W-1:0] u_wdata,
  output logic             u_ready,
  input  wire logic        use_pb,
  input  wire logic        burst_req,
  output logic             burst_mode,
  output logic [BAW-1:0]   pb_ptr,
  output logic [OWED_W-1:0] owed
);

  typedef struct packed {
    rfsh_ph_e          ph;
    logic [NB-1:0]     open;
    logic [OWED_W-1:0] owed;
    logic [TW+2:0]     refi;
    logic [WIN_W-1:0]  win;
    logic              burst;
    logic [BAW-1:0]    ptr;
    logic [2:0]        wcnt;
    logic [GRP_W-1:0]  wdat;
    logic              cs_n;
    logic [CAW-1:0]    ca;
    logic [BAW-1:0]    ba;
    logic              wd_valid;
    logic [BEAT_W-1:0] wd;
  } rfsh_ctl_s;

  rfsh_ctl_s c_reg;
  rfsh_ctl_s c_next;

  logic [NB-1:0] rp_b, wr_b, pbb_b, rp_ld, wr_ld, pbb_ld;
  logic ab_b, pb_b, gap_b, rrd_b;
  logic iss_ab, iss_pb, iss_act, iss_wr, iss_pre;
  logic ab_ok, pb_ok, pa_ok, user_ok, refi_tick, win_tick;

  // ==========================================================
  // Decode of the command being launched this edge
  assign iss_ab  = !c_next.cs_n && (c_next.ca[2:0] == CA_REF) && c_next.ca[CA_SEL];
  assign iss_pb  = !c_next.cs_n && (c_next.ca[2:0] == CA_REF) && !c_next.ca[CA_SEL];
  assign iss_act = !c_next.cs_n && (c_next.ca[1:0] == CA_ACT);
  assign iss_wr  = !c_next.cs_n && (c_next.ca[2:0] == CA_WR);
  assign iss_pre = !c_next.cs_n && (c_next.ca[2:0] == CA_PRE);

  // ==========================================================
  // Global separation timers
  rfsh_tmr u_ab (
    .sys_clk (sys_clk), .rstn (rstn), .load (iss_ab), .val (TW'(RFCAB_CYC)), .busy (ab_b)
  );
  rfsh_tmr u_gap (
    .sys_clk (sys_clk), .rstn (rstn), .load (iss_ab), .val (TW'(AB_GAP_CYC)), .busy (gap_b)
  );
  rfsh_tmr u_pb (
    .sys_clk (sys_clk), .rstn (rstn), .load (iss_pb), .val (TW'(RFCPB_CYC)), .busy (pb_b)
  );
  rfsh_tmr u_rrd (
    .sys_clk (sys_clk), .rstn (rstn), .load (iss_act || iss_pb), .val (TW'(RRD_CYC)), .busy (rrd_b)
  );

  // ==========================================================
  // Per-bank timers: precharge, write recovery, per-bank refresh
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_bank
      assign rp_ld[gi]  = iss_pre && (c_next.ca[CA_ALL] || (c_next.ba == BAW'(gi)));
      assign wr_ld[gi]  = iss_wr && (c_next.ba == BAW'(gi));
      assign pbb_ld[gi] = iss_pb && (c_next.ba == BAW'(gi));
      rfsh_tmr u_rp (
        .sys_clk (sys_clk), .rstn (rstn), .load (rp_ld[gi]), .val (TW'(RP_CYC)), .busy (rp_b[gi])
      );
      rfsh_tmr u_wr (
        .sys_clk (sys_clk), .rstn (rstn), .load (wr_ld[gi]), .val (TW'(WR_REC_CYC)), .busy (wr_b[gi])
      );
      rfsh_tmr u_pbb (
        .sys_clk (sys_clk), .rstn (rstn), .load (pbb_ld[gi]), .val (TW'(RFCPB_CYC)), .busy (pbb_b[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Refresh eligibility
  assign refi_tick = (c_reg.refi == (TW + 3)'(REFI_CYC - 1));
  assign win_tick  = (c_reg.win == WIN_W'(REFW_CYCLES - 1));
  // All-bank form needs every bank idle and precharged
  assign ab_ok = !use_pb && (c_reg.owed != '0) && (c_reg.open == '0) && (rp_b == '0)
                 && !ab_b && !pb_b && !gap_b;
  // Per-bank form targets the mirrored counter's bank only
  assign pb_ok = use_pb && (c_reg.owed != '0) && !c_reg.open[c_reg.ptr] && !rp_b[c_reg.ptr]
                 && !ab_b && !pb_b && !rrd_b;
  // Drain open banks before an all-bank refresh
  assign pa_ok = (c_reg.ph == PH_DRAIN) && !use_pb && (wr_b == '0) && (c_reg.wcnt == '0);

  // ==========================================================
  // Readiness of the offered user request
  always_comb
  begin
    user_ok = 1'b0;
    case (u_op)
      OP_ACT:
        user_ok = !c_reg.open[u_bank] && !rp_b[u_bank] && !pbb_b[u_bank] && !ab_b && !rrd_b
                  && (c_reg.ph == PH_RUN || use_pb)
                  && !(use_pb && c_reg.owed != '0 && u_bank == c_reg.ptr);
      OP_WR:
        user_ok = c_reg.open[u_bank] && (c_reg.wcnt == '0);
      OP_PRE:
        user_ok = u_all ? (wr_b == '0) : (c_reg.open[u_bank] && !wr_b[u_bank]);
      default:
        user_ok = 1'b0;
    endcase
  end

  // Refresh work takes priority over user traffic
  assign u_ready = user_ok && !ab_ok && !pb_ok && !pa_ok;

  // ==========================================================
  // Next-state: schedule, command launch, write data
  always_comb
  begin
    c_next          = c_reg;
    c_next.cs_n     = 1'b1;
    c_next.ca       = {2'h0, CA_NOP};
    c_next.wd_valid = 1'b0;
    c_next.refi     = refi_tick ? '0 : c_reg.refi + (TW + 3)'(1);
    c_next.win      = (win_tick || !c_reg.burst) ? '0 : c_reg.win + WIN_W'(1);
    // Distributed: one refresh owed per interval
    if (!c_reg.burst && refi_tick && c_reg.owed != OWED_W'(REF_COUNT))
      c_next.owed = c_reg.owed + OWED_W'(1);
    // Burst: whole count due at each window start, pause follows
    if (c_reg.burst && win_tick)
      c_next.owed = OWED_W'(REF_COUNT);
    if (ab_ok)
    begin
      c_next.cs_n         = 1'b0;
      c_next.ca           = {1'b0, 1'b1, CA_REF};
      c_next.owed         = c_next.owed - OWED_W'(1);
      c_next.ptr          = '0;
    end
    else if (pb_ok)
    begin
      c_next.cs_n = 1'b0;
      c_next.ca   = {1'b0, 1'b0, CA_REF};
      c_next.ba   = c_reg.ptr;
      c_next.ptr  = c_reg.ptr + BAW'(1);
      if (c_reg.ptr == BAW'(NB - 1))
        c_next.owed = c_next.owed - OWED_W'(1);
    end
    else if (pa_ok)
    begin
      c_next.cs_n = 1'b0;
      c_next.ca   = {1'b1, 1'b1, CA_PRE};
      c_next.open = '0;
    end
    else if (u_valid && u_ready)
    begin
      c_next.cs_n = 1'b0;
      c_next.ba   = u_bank;
      case (u_op)
        OP_ACT:
        begin
          c_next.ca            = {3'h0, CA_ACT};
          c_next.open[u_bank] = 1'b1;
        end
        OP_WR:
        begin
          c_next.ca   = {2'h0, CA_WR};
          c_next.wcnt = 3'(WL + BEATS);
          c_next.wdat = u_wdata;
        end
        default:
        begin
          c_next.ca = {u_all, 1'b1, CA_PRE};
          if (u_all)
            c_next.open = '0;
          else
            c_next.open[u_bank] = 1'b0;
        end
      endcase
    end
    // Write beats WL cycles after the command, low half first
    if (c_reg.wcnt != '0)
    begin
      c_next.wcnt     = c_reg.wcnt - 3'(1);
      c_next.wd_valid = (c_next.wcnt != '0) && (c_next.wcnt <= 3'(BEATS));
      c_next.wd       = (c_next.wcnt == 3'(BEATS)) ? c_reg.wdat[BEAT_W-1:0] : c_reg.wdat[GRP_W-1:BEAT_W];
    end
    // Leave burst only at the close of a burst phase
    if (c_reg.burst && !burst_req && c_reg.owed != '0 && c_next.owed == '0 && (ab_ok || pb_ok))
      c_next.burst = 1'b0;
    else if (!c_reg.burst && burst_req && c_reg.owed == '0)
    begin
      c_next.burst = 1'b1;
      c_next.owed  = OWED_W'(REF_COUNT);
    end
    // Phase follows outstanding refresh work
    case (c_reg.ph)
      PH_RUN, PH_DRAIN, PH_REF:
        c_next.ph = (c_next.owed == '0) ? PH_RUN : ((c_next.open != '0) ? PH_DRAIN : PH_REF);
      default:
        c_next.ph = PH_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      c_reg      <= '0;
      c_reg.ph   <= PH_RUN;
      c_reg.cs_n <= 1'b1;
      c_reg.ca   <= {2'h0, CA_NOP};
    end
    else
      c_reg <= c_next;
  end

  assign link.cs_n     = c_reg.cs_n;
  assign link.ca       = c_reg.ca;
  assign link.ba       = c_reg.ba;
  assign link.wd_valid = c_reg.wd_valid;
  assign link.wd       = c_reg.wd;
  assign burst_mode    = c_reg.burst;
  assign pb_ptr        = c_reg.ptr;
  assign owed          = c_reg.owed;

endmodule : rfsh_ctl

// ---- sim/rfsh_assertions.sv ----
// Checker for the controller-to-device command link
`timescale 1ns/1ps
module rfsh_assertions import rfsh_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic              cs_n,
  input wire logic [CAW-1:0]    ca,
  input wire logic [BAW-1:0]    ba,
  input wire logic              wd_valid,
  input wire logic [BEAT_W-1:0] wd
);
  // ====================
  // Command decode
  logic           act, wr, pre, all_bank_refresh_cmd, per_bank_refresh_cmd;
  logic [NB-1:0]  open_q;
  logic [BAW-1:0] pb_q, wrb_q;
  logic [3:0]     ab_cnt, wr_cnt;

  // Decoded from the wire alone, so the checker needs no design internals
  assign act   = !cs_n && ca[1:0] == CA_ACT;
  assign wr    = !cs_n && ca[2:0] == CA_WR;
  assign pre   = !cs_n && ca[2:0] == CA_PRE;
  assign all_bank_refresh_cmd = !cs_n && ca[2:0] == CA_REF && ca[CA_SEL];
  assign per_bank_refresh_cmd = !cs_n && ca[2:0] == CA_REF && !ca[CA_SEL];

  // ====================
  // Shadow state
  // Counters saturate so a long idle never wraps into a false short gap
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      open_q <= 8'h00;
      pb_q   <= 3'h0;
      wrb_q  <= 3'h0;
      ab_cnt <= 4'hF;
      wr_cnt <= 4'hF;
    end
    else
    begin
      if (act)
        open_q <= open_q | (8'h01 << ba);
      else if (pre)
        open_q <= ca[CA_ALL] ? 8'h00 : open_q & ~(8'h01 << ba);
      if (all_bank_refresh_cmd)
        pb_q <= 3'h0;
      else if (per_bank_refresh_cmd)
        pb_q <= pb_q + 3'h1;
      if (wr)
        wrb_q <= ba;
      ab_cnt <= all_bank_refresh_cmd ? 4'h0 : ab_cnt + {3'h0, ab_cnt != 4'hF};
      wr_cnt <= wr ? 4'h0 : wr_cnt + {3'h0, wr_cnt != 4'hF};
    end

  // ====================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_write;
    wr;
  endsequence
  sequence s_beats;
    wd_valid ##1 wd_valid ##1 !wd_valid;
  endsequence

  wr_beats_a: assert property (s_write |=> s_beats)
    else $error("write beats not two in a row");
  wr_pre_a: assert property (pre && (ca[CA_ALL] || ba == wrb_q) |-> wr_cnt >= WR_REC_CYC - 1)
    else $error("precharge too soon after write");
  ab_space_a: assert property (all_bank_refresh_cmd |-> ab_cnt >= AB_GAP_CYC - 1)
    else $error("all-bank refreshes too close");
  ab_quiet_a: assert property (all_bank_refresh_cmd |=> !(act || all_bank_refresh_cmd || per_bank_refresh_cmd))
    else $error("command inside all-bank refresh cycle");
  ab_idle_a: assert property (all_bank_refresh_cmd |-> open_q == 8'h00)
    else $error("all-bank refresh with a bank open");
  act_ref_a: assert property (act |=> !all_bank_refresh_cmd)
    else $error("all-bank refresh right after activate");
  pb_order_a: assert property (per_bank_refresh_cmd |-> ba == pb_q)
    else $error("per-bank refresh out of order");
  pb_idle_a: assert property (per_bank_refresh_cmd |-> !open_q[ba])
    else $error("per-bank refresh to open bank");
endmodule : rfsh_assertions

// ---- sim/sdram_refresh_scheduling_test.sv ----
// Bench joining both ends of the refresh-scheduling link
`timescale 1ns/1ps
module sdram_refresh_scheduling_test import rfsh_pkg::*;
  ;
  // ====================
  // Signals and instances
  logic              sys_clk, rstn, u_valid, u_all, u_ready, use_pb, burst_req;
  logic              burst_mode, reset_cmd, sr_exit, arr_we, cmd_err, err2;
  rfsh_op_e          u_op;
  logic [BAW-1:0]    u_bank, pb_ptr, ref_ptr, ptr2, arr_bank;
  logic [GRP_W-1:0]  u_wdata, arr_data;
  logic [OWED_W-1:0] owed;
  logic [NB-1:0]     bank_open, bank_rfsh, open2, rfsh2;
  int                mismatches = 0;
  int                checked = 0;
  int                cyc = 0;
  int                dev_errs = 0;

  rfsh_if lk();
  rfsh_if lk2();

  // Short window of 200 cycles, still longer than the burst phase, so no reload tick falls inside the run
  rfsh_ctl #(.REFW_CYCLES(200)) i_rfsh_ctl (.sys_clk, .rstn, .link(lk), .u_valid, .u_op, .u_bank, .u_all,
    .u_wdata, .u_ready, .use_pb, .burst_req, .burst_mode, .pb_ptr, .owed);
  rfsh_dev i_rfsh_dev (.sys_clk, .rstn, .link(lk), .reset_cmd, .sr_exit, .bank_open, .bank_rfsh, .ref_ptr,
    .arr_we, .arr_bank, .arr_data, .cmd_err);
  // Second device without per-bank support, fed faults by the bench
  rfsh_dev #(.EIGHT_BANKS(1'b0)) i_rfsh_dev_4 (.sys_clk, .rstn, .link(lk2), .reset_cmd(1'b0), .sr_exit(1'b0),
    .bank_open(open2), .bank_rfsh(rfsh2), .ref_ptr(ptr2), .arr_we(), .arr_bank(), .arr_data(), .cmd_err(err2));
  rfsh_assertions i_chk (.sys_clk, .rstn, .cs_n(lk.cs_n), .ca(lk.ca), .ba(lk.ba), .wd_valid(lk.wd_valid),
    .wd(lk.wd));

  // Clock and cycle count
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // Legal traffic from the controller must never be refused by the device
  always @(posedge sys_clk) if (cmd_err === 1'b1) dev_errs <= dev_errs + 1;

  // ====================
  // Helpers
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Edges pass, then land just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wait_ref(input logic ab);
    for (int i = 0; i < 400; i++)
    begin
      if (lk.cs_n === 1'b0 && lk.ca[2:0] === CA_REF && lk.ca[CA_SEL] === ab)
        return;
      tick(1);
    end
    mismatches++;
    test_done();
  endtask : wait_ref

  // Hold the request until ready is seen, then drop it after the taking edge
  task automatic issue(input rfsh_op_e op, input logic [BAW-1:0] b);
    int i;
    u_op = op;
    u_bank = b;
    u_valid = 1'b1;
    for (i = 0; i < 400; i++)
    begin
      #1;
      if (u_ready === 1'b1)
        break;
      tick(1);
    end
    if (i == 400)
    begin
      mismatches++;
      test_done();
    end
    tick(1);
    u_valid = 1'b0;
  endtask : issue

  // Raw command on the second link; stays on the wire until replaced
  task automatic drv(input logic [CAW-1:0] c, input logic [BAW-1:0] b);
    lk2.cs_n = 1'b0;
    lk2.ca = c;
    lk2.ba = b;
    tick(1);
  endtask : drv

  // ====================
  // Scenarios
  task automatic sc_write;
    logic [GRP_W-1:0] d;
    int w;
    d = 64'h0123_4567_89AB_CDEF;
    issue(OP_ACT, 3'h2);
    tick(1);
    chk("open", 1'b1, bank_open[2]);
    u_wdata = d;
    issue(OP_WR, 3'h2);
    w = cyc;
    tick(1);
    chk("beat0", d[31:0], lk.wd);
    tick(1);
    chk("beat1", d[63:32], lk.wd);
    tick(1);
    chk("arr_we", 1'b1, arr_we);
    chk("arr_data", d, arr_data);
    chk("arr_bank", 3'h2, arr_bank);
    // Precharge-all asked at once, must wait out the recovery
    u_all = 1'b1;
    issue(OP_PRE, 3'h2);
    u_all = 1'b0;
    chk("wr_pre", 1'b1, (cyc - w) >= WR_REC_CYC);
    tick(1);
    chk("closed", 8'h00, bank_open);
  endtask : sc_write

  // Once round the counter and one step past the wrap
  task automatic sc_perbank;
    logic [BAW-1:0] e;
    e = 3'h0;
    use_pb = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      wait_ref(1'b0);
      chk("pb_ca", 4'h4, lk.ca[3:0]);
      chk("pb_ba", e, lk.ba);
      e = e + 3'h1;
      // Copy steps at launch, one cycle ahead of the device's counter
      chk("pb_copy", e, pb_ptr);
      if (k == 8)
        use_pb = 1'b0;
      tick(1);
      chk("ref_ptr", e, ref_ptr);
      chk("pb_idle", 1'b0, bank_open[e - 3'h1]);
    end
  endtask : sc_perbank

  // Counter clears from each source while per-bank refreshes keep stepping it
  task automatic sc_resync;
    use_pb = 1'b1;
    wait_ref(1'b0);
    reset_cmd = 1'b1;
    tick(1);
    reset_cmd = 1'b0;
    chk("rst_clr", 3'h0, ref_ptr);
    tick(1);
    chk("pb_one", 3'h1, ref_ptr);
    sr_exit = 1'b1;
    tick(1);
    sr_exit = 1'b0;
    chk("sr_clr", 3'h0, ref_ptr);
    // Leaving per-bank mode with a unit owed brings an all-bank refresh
    use_pb = 1'b0;
    wait_ref(1'b1);
    chk("ab_ca", 5'h0C, lk.ca);
    chk("ctl_clr", 3'h0, pb_ptr);
    tick(1);
    chk("ab_busy", 8'hFF, bank_rfsh);
    chk("ab_clr", 3'h0, ref_ptr);
    tick(1);
    chk("ab_done", 8'h00, bank_rfsh | bank_open);
    // An open bank must be drained before the next all-bank refresh
    issue(OP_ACT, 3'h5);
    wait_ref(1'b1);
    chk("idle_ab", 8'h00, bank_open);
  endtask : sc_resync

  // Back-to-back illegal and legal commands into the second device
  task automatic sc_fault;
    drv(5'h04, 3'h3);
    chk("pb_refused", 1'b1, err2);
    chk("pb_ptr_kept", 3'h0, ptr2);
    drv(5'h02, 3'h1);
    chk("act_ok", 1'b0, err2);
    drv(5'h0C, 3'h0);
    chk("ab_refused", 1'b1, err2);
    drv(5'h13, 3'h0);
    drv(5'h0C, 3'h0);
    chk("ab_ok", 8'hFF, rfsh2);
    drv(5'h02, 3'h4);
    chk("act_busy", 1'b1, err2);
    drv(5'h02, 3'h4);
    chk("act_late", 1'b1, open2[4]);
    // Refresh code without chip select must be ignored
    lk2.cs_n = 1'b1;
    lk2.ca = 5'h0C;
    lk2.ba = 3'h3;
    tick(1);
    chk("cs_gate", 1'b0, err2 | rfsh2[0]);
  endtask : sc_fault

  task automatic sc_burst;
    int n;
    burst_req = 1'b1;
    for (int i = 0; i < 20 && burst_mode !== 1'b1; i++)
      tick(1);
    chk("burst_mode", 1'b1, burst_mode);
    chk("owed_load", 1'b1, owed >= REF_COUNT - 8);
    n = 0;
    for (int i = 0; i < 6 * AB_GAP_CYC; i++)
    begin
      if (lk.cs_n === 1'b0 && lk.ca === 5'h0C)
        n++;
      tick(1);
    end
    chk("burst_rate", 1'b1, n >= 4);
    burst_req = 1'b0;
  endtask : sc_burst

  // ====================
  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {u_valid, u_all, use_pb, burst_req, reset_cmd, sr_exit} = 6'h00;
    u_op = OP_ACT;
    u_bank = 3'h0;
    u_wdata = 64'h0;
    lk2.cs_n = 1'b1;
    lk2.ca = 5'h07;
    lk2.ba = 3'h0;
    lk2.wd_valid = 1'b0;
    lk2.wd = 32'h0;
    tick(6);
    rstn = 1'b1;
    wait_ref(1'b1);
    tick(2);
    sc_write();
    sc_perbank();
    sc_resync();
    sc_fault();
    sc_burst();
    chk("cmd_err", 0, dev_errs);
    test_done();
  end
endmodule : sdram_refresh_scheduling_test
